// File: hw/cifs_core.sv
// cifs_core: tamper fault detection and current input selection with
// register port, gain trim for the second input and digital integrator.
// Assumes a synchronous byte register port from the processor core and
// sample strobes on clk_sys_i.
//
// Summary of operation
// - fault when inputs differ by over 6.25 percent of active input.
// - on fault, move to inactive input when it is larger.
// - during fault, measure from whichever input is larger.
// - after reset the first input is the measurement source.
// - fault comparison averaged; recognised about one second after event.
// - fault detection off while voltage below 0.3 percent full scale.
// - active input reported on bit 7 of accumulation mode.
// - force field 01 picks first, 10 second; 00/11 automatic.
// - fault state change sets flag bit 5 of irq status low.
// - with mode bit 6 clear, flag set on entering and leaving fault.
// - interrupt pending while flag and enable bit 5 both set.
// - second below 93.75 percent of first: flag set, no swap.
// - inputs filtered and averaged, flag about one second late.
// - second exceeds first by 6.25 percent: flag, swap after 3 s.
// - swap back only when first exceeds second by 6.25 percent.
// - with bit 6 set, flag when first comes within 6.25 percent.
// - second input scaled by 12-bit signed trim, 0.0244 percent per lsb.
// - integrator off after reset, on with mode one bit 5.
// - integrator gives -20 dB/decade and about -90 degree shift.
`timescale 1ns/1ps
module cifs_core
  import cifs_pkg::*;
#(
  parameter longint AVG_CYC  = AVG_CYCLES,
  parameter longint SWAP_CYC = SWAP_CYCLES
)
(
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  input  wire logic [7:0]          reg_addr_i,
  input  wire logic [7:0]          reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output logic      [7:0]          reg_rdata_o,
  input  wire logic                sample_stb_i,
  input  wire logic [SAMPLE_W-1:0] primary_current_input_i,
  input  wire logic [SAMPLE_W-1:0] secondary_current_input_i,
  input  wire logic [SAMPLE_W-1:0] voltage_i,
  output logic      [SAMPLE_W-1:0] current_o,
  output logic                     active_input_indicator_o,
  output logic                     fault_o,
  output logic                     irq_o
);
  logic [7:0]              metering_mode_one;
  logic                    fault_mode;
  logic [1:0]              input_force_select;
  logic [7:0]              calibration_mode;
  logic [GAIN_W-1:0]       second_input_gain_trim;
  logic [7:0]              metering_irq_enable_low;
  logic                    fault_change_flag;
  logic                    active_input_indicator;
  logic                    in_fault;
  logic [MAG_W-1:0]        mag_a;
  logic [MAG_W-1:0]        mag_b;
  logic [MAG_W-1:0]        mag_v;
  logic [SAMPLE_W-1:0]     trimmed_b;
  logic [31:0]             avg_cnt;
  logic [31:0]             swap_cnt;
  logic                    raw_fault;
  logic                    want_b;
  logic                    want_a;
  logic                    near_event;
  logic                    near_prev;
  logic                    set_flag;
  logic                    clr_flag;
  logic [SAMPLE_W+INTEG_LEAK-1:0] integ;
  logic signed [SAMPLE_W+INTEG_LEAK-1:0] integ_leak;
  logic [SAMPLE_W-1:0]     sel_sample;

  // x exceeds y by more than y/16
  function automatic logic over16(input logic [MAG_W-1:0] x,
                                  input logic [MAG_W-1:0] y);
    return {1'b0, x} > ({1'b0, y} + {1'b0, (y >> FAULT_SHIFT)});
  endfunction

  // y falls short of x by more than x/16
  function automatic logic under16(input logic [MAG_W-1:0] x,
                                   input logic [MAG_W-1:0] y);
    return ({1'b0, y} + {1'b0, (x >> FAULT_SHIFT)}) < {1'b0, x};
  endfunction

  // second input with gain trim, 2^-12 per lsb
  function automatic logic [SAMPLE_W-1:0] trim(input logic [SAMPLE_W-1:0] s,
                                   input logic [GAIN_W-1:0] g);
    logic signed [SAMPLE_W+GAIN_W:0] p;
    p = $signed({s[SAMPLE_W-1], s}) * $signed(g);
    return SAMPLE_W'($signed({s[SAMPLE_W-1], s}) + (p >>> GAIN_W));
  endfunction

  always_comb begin
    trimmed_b = trim(secondary_current_input_i, second_input_gain_trim);
  end

  cifs_mag_filter u_filt_a (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .strobe_i  (sample_stb_i),
    .sample_i  (primary_current_input_i),
    .mag_o     (mag_a)
  );

  cifs_mag_filter u_filt_b (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .strobe_i  (sample_stb_i),
    .sample_i  (trimmed_b),
    .mag_o     (mag_b)
  );

  cifs_mag_filter u_filt_v (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .strobe_i  (sample_stb_i),
    .sample_i  (voltage_i),
    .mag_o     (mag_v)
  );

  always_comb begin
    input_force_select = calibration_mode[BIT_FORCE_LO+1:BIT_FORCE_LO];
    // fault measured against the active input
    if (active_input_indicator) begin
      raw_fault = over16(mag_a, mag_b) || under16(mag_b, mag_a);
    end else begin
      raw_fault = over16(mag_b, mag_a) || under16(mag_a, mag_b);
    end
    if (mag_v < VOLT_MIN) begin
      raw_fault = 1'b0;
    end
    // hysteresis: either swap needs a lead of 1/16 of the second input
    want_b = (mag_v >= VOLT_MIN) && under16(mag_b, mag_a);
    want_a = (mag_v >= VOLT_MIN) && over16(mag_a, mag_b);
    near_event = (mag_v >= VOLT_MIN) && !under16(mag_b, mag_a)
                 && !over16(mag_a, mag_b);
  end

  // fault must persist for the averaging time before it is believed
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      avg_cnt <= '0;
      in_fault <= 1'b0;
    end else if (raw_fault == in_fault) begin
      avg_cnt <= '0;
    end else if (avg_cnt >= 32'(AVG_CYC - 1)) begin
      avg_cnt <= '0;
      in_fault <= raw_fault;
    end else begin
      avg_cnt <= avg_cnt + 32'd1;
    end
  end

  // automatic swap with hysteresis, delayed by the swap time
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      active_input_indicator <= 1'b0;
      swap_cnt <= '0;
    end else if (input_force_select == FORCE_PRIMARY) begin
      active_input_indicator <= 1'b0;
      swap_cnt <= '0;
    end else if (input_force_select == FORCE_SECONDARY) begin
      active_input_indicator <= 1'b1;
      swap_cnt <= '0;
    end else if ((!active_input_indicator && want_b) ||
                 (active_input_indicator && want_a)) begin
      if (swap_cnt >= 32'(SWAP_CYC - 1)) begin
        active_input_indicator <= !active_input_indicator;
        swap_cnt <= '0;
      end else begin
        swap_cnt <= swap_cnt + 32'd1;
      end
    end else begin
      swap_cnt <= '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      near_prev <= 1'b0;
    end else begin
      near_prev <= near_event;
    end
  end

  // fault change detect on the believed state
  logic fault_prev;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fault_prev <= 1'b0;
    end else begin
      fault_prev <= in_fault;
    end
  end

  always_comb begin
    if (fault_mode) begin
      set_flag = near_event && !near_prev;
    end else begin
      set_flag = in_fault != fault_prev;
    end
    // write-zero-to-clear on the flag bit
    clr_flag = reg_wr_i && (reg_addr_i == ADDR_IRQ_ST_LOW)
               && !reg_wdata_i[BIT_FAULT_CHG];
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fault_change_flag <= 1'b0;
    end else if (set_flag) begin
      fault_change_flag <= 1'b1;
    end else if (clr_flag) begin
      fault_change_flag <= 1'b0;
    end
  end

  // register writes
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      metering_mode_one       <= RST_BYTE;
      fault_mode              <= 1'b0;
      calibration_mode        <= RST_BYTE;
      second_input_gain_trim  <= RST_GAIN;
      metering_irq_enable_low <= RST_BYTE;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_MODE_ONE:   metering_mode_one <= reg_wdata_i;
        ADDR_ACC_MODE:   fault_mode <= reg_wdata_i[BIT_FAULT_MODE];
        ADDR_CAL_MODE:   calibration_mode <= reg_wdata_i;
        ADDR_GAIN_LO:    second_input_gain_trim[7:0] <= reg_wdata_i;
        ADDR_GAIN_HI:    second_input_gain_trim[11:8] <= reg_wdata_i[3:0];
        ADDR_IRQ_EN_LOW: metering_irq_enable_low <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // register reads
  // unmapped offsets read as zero
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_o <= RST_BYTE;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_MODE_ONE:   reg_rdata_o <= metering_mode_one;
        ADDR_ACC_MODE:   reg_rdata_o <= {active_input_indicator, fault_mode,
                                         6'h00};
        ADDR_CAL_MODE:   reg_rdata_o <= calibration_mode;
        ADDR_GAIN_LO:    reg_rdata_o <= second_input_gain_trim[7:0];
        ADDR_GAIN_HI:    reg_rdata_o <= {4'h0,
                                         second_input_gain_trim[11:8]};
        ADDR_IRQ_EN_LOW: reg_rdata_o <= metering_irq_enable_low;
        ADDR_IRQ_ST_LOW: reg_rdata_o <= {2'b00, fault_change_flag, 5'h00};
        default:         reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // measurement path follows the active input
  always_comb begin
    sel_sample = active_input_indicator ? trimmed_b
                                        : primary_current_input_i;
  end

  // arithmetic shift so a negative total leaks toward zero
  always_comb begin
    integ_leak = $signed(integ) >>> INTEG_LEAK;
  end

  // leaky accumulator: ~-20 dB/dec and ~-90 deg above the leak corner
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !metering_mode_one[BIT_INTEG_ON]) begin
      integ <= '0;
    end else if (sample_stb_i) begin
      integ <= integ - integ_leak
               + {{INTEG_LEAK{sel_sample[SAMPLE_W-1]}}, sel_sample};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      current_o                <= '0;
      active_input_indicator_o <= 1'b0;
      fault_o                  <= 1'b0;
      irq_o                    <= 1'b0;
    end else begin
      current_o <= metering_mode_one[BIT_INTEG_ON]
                   ? integ[SAMPLE_W+INTEG_LEAK-1:INTEG_LEAK]
                   : sel_sample;
      active_input_indicator_o <= active_input_indicator;
      fault_o <= in_fault;
      irq_o <= fault_change_flag &&
               metering_irq_enable_low[BIT_FAULT_CHG];
    end
  end
endmodule

// File: hw/cifs_pkg.sv
// cifs_pkg: register map, field positions, thresholds and timing counts
// for the current input fault selector; shared by the core and its filter.
package cifs_pkg;
  localparam int          SAMPLE_W         = 24;
  localparam int          MAG_W            = 24;
  // register offsets
  localparam logic [7:0]  ADDR_MODE_ONE    = 8'h0B;
  localparam logic [7:0]  ADDR_ACC_MODE    = 8'h0F;
  localparam logic [7:0]  ADDR_GAIN_LO     = 8'h1C;
  localparam logic [7:0]  ADDR_GAIN_HI     = 8'h1D;
  localparam logic [7:0]  ADDR_CAL_MODE    = 8'h3D;
  localparam logic [7:0]  ADDR_IRQ_EN_LOW  = 8'hD9;
  localparam logic [7:0]  ADDR_IRQ_ST_LOW  = 8'hDC;
  // field positions
  localparam int          BIT_INTEG_ON     = 5;
  localparam int          BIT_ACTIVE_IND   = 7;
  localparam int          BIT_FAULT_MODE   = 6;
  localparam int          BIT_FORCE_LO     = 4;
  localparam int          BIT_FAULT_CHG    = 5;
  localparam int          GAIN_W           = 12;
  // reset values
  localparam logic [7:0]  RST_BYTE         = 8'h00;
  localparam logic [11:0] RST_GAIN         = 12'h000;
  // force-select codes
  localparam logic [1:0]  FORCE_PRIMARY    = 2'b01;
  localparam logic [1:0]  FORCE_SECONDARY  = 2'b10;
  // thresholds: 6.25 % = 1/16, 93.75 % = 15/16
  localparam int          FAULT_SHIFT      = 4;
  // 0.3 % of full scale (0x800000) ~ 0x0064B0
  localparam logic [23:0] VOLT_MIN         = 24'h0064B0;
  // timing
  localparam int          CLK_HZ           = 25_000_000;
  localparam int          AVG_TIME_MS      = 1000;
  localparam int          SWAP_TIME_MS     = 3000;
  localparam longint      AVG_CYCLES       =
    longint'(CLK_HZ) * AVG_TIME_MS / 1000;
  localparam longint      SWAP_CYCLES      =
    longint'(CLK_HZ) * SWAP_TIME_MS / 1000;
  localparam int          FILT_SHIFT       = 10;
  // integrator leak shift
  localparam int          INTEG_LEAK       = 12;
endpackage

// File: hw/cifs_mag_filter.sv
// cifs_mag_filter: rectifies a signed sample and low-pass filters it into
// an averaged magnitude. Assumes samples arrive with a one-cycle strobe.
`timescale 1ns/1ps
module cifs_mag_filter
  import cifs_pkg::*;
(
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  input  wire logic                strobe_i,
  input  wire logic [SAMPLE_W-1:0] sample_i,
  output logic      [MAG_W-1:0]    mag_o
);
  logic [MAG_W+FILT_SHIFT-1:0] acc;
  logic [MAG_W-1:0]            rect;

  always_comb begin
    rect = sample_i[SAMPLE_W-1] ? MAG_W'(-sample_i) : sample_i;
  end

  // single-pole average; slow by design to reject transients
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      acc <= '0;
    end else if (strobe_i) begin
      acc <= acc - (acc >> FILT_SHIFT) + {{FILT_SHIFT{1'b0}}, rect};
    end
  end

  assign mag_o = acc[MAG_W+FILT_SHIFT-1:FILT_SHIFT];
endmodule

// File: tb/cifs_cpu_model.sv
// cifs_cpu_model: processor-side register master for cifs_core.
// Assumes the core takes a strobe on the rising edge of clk_sys_i.
`timescale 1ns/1ps
module cifs_cpu_model (
  input  wire logic       clk_sys_i,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  end
  // released lines flip so a stale value never passes for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(posedge clk_sys_i);
    #1;
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~a;
    reg_wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(posedge clk_sys_i);
    #1;
    reg_rd_o   = 1'b0;
    reg_addr_o = ~a;
    d          = reg_rdata_i;
  endtask
endmodule

// File: tb/cifs_core_chk.sv
// cifs_core_chk: port assertions for cifs_core, bound below.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module cifs_core_chk
  import cifs_pkg::*;
#(parameter longint AVG_CYC = AVG_CYCLES)
(
  input wire logic                clk_sys_i,
  input wire logic                rst_i,
  input wire logic [7:0]          reg_addr_i,
  input wire logic [7:0]          reg_wdata_i,
  input wire logic                reg_wr_i,
  input wire logic                reg_rd_i,
  input wire logic [7:0]          reg_rdata_o,
  input wire logic [SAMPLE_W-1:0] voltage_i,
  input wire logic                active_input_indicator_o,
  input wire logic                fault_o,
  input wire logic                irq_o
);
  logic [1:0] frc;
  logic       en;
  logic       vseen;
  longint     up;
  logic       wr_st;
  assign wr_st = reg_wr_i && (reg_addr_i == ADDR_IRQ_ST_LOW ||
                              reg_addr_i == ADDR_IRQ_EN_LOW);
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      frc <= 2'b00;
      en  <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == ADDR_CAL_MODE) begin
      frc <= reg_wdata_i[5:4];
    end else if (reg_wr_i && reg_addr_i == ADDR_IRQ_EN_LOW) begin
      en <= reg_wdata_i[5];
    end
  end
  // only an all-zero voltage history is sure to keep the gate shut
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) vseen <= 1'b0;
    else if (voltage_i != '0) vseen <= 1'b1;
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) up <= 0;
    else if (up < AVG_CYC) up <= up + 1;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_forced(logic [1:0] c);
    frc == c ##1 frc == c;
  endsequence
  sequence s_st_quiet;
    !wr_st ##1 (irq_o && !wr_st);
  endsequence
  a_reset_clean: assert property ($fell(rst_i) |->
    !fault_o && !active_input_indicator_o && !irq_o && reg_rdata_o == 8'h00)
    else $error("outputs not clear after reset");
  a_fault_late: assert property (up < AVG_CYC |-> !fault_o)
    else $error("fault raised before averaging time");
  a_volt_gate: assert property (!vseen |-> !fault_o)
    else $error("fault raised with no voltage");
  a_acc_read: assert property (
    reg_rd_i && reg_addr_i == ADDR_ACC_MODE |=> reg_rdata_o[5:0] == 6'h00
    && reg_rdata_o[7] == active_input_indicator_o)
    else $error("accumulation mode read wrong");
  a_force_second: assert property (
    s_forced(FORCE_SECONDARY) |=> active_input_indicator_o)
    else $error("forced second input not in use");
  a_force_first: assert property (
    s_forced(FORCE_PRIMARY) |=> !active_input_indicator_o)
    else $error("forced first input not in use");
  a_irq_masked: assert property (!en ##1 !en |-> !irq_o)
    else $error("interrupt while disabled");
  a_irq_hold: assert property (s_st_quiet |=> irq_o)
    else $error("interrupt dropped without a clear");
endmodule

bind cifs_core cifs_core_chk #(.AVG_CYC(AVG_CYC)) u_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .voltage_i(voltage_i), .fault_o(fault_o),
  .active_input_indicator_o(active_input_indicator_o), .irq_o(irq_o));

// File: tb/cifs_core_test.sv
// cifs_core_test: register and fault-path tests for cifs_core.
// Assumes cifs_cpu_model as register master and steady dc samples.
`timescale 1ns/1ps
module cifs_core_test;
  import cifs_pkg::*;
  logic                clk_sys_i = 1'b0;
  logic                rst_i     = 1'b1;
  logic                stb       = 1'b0;
  logic [SAMPLE_W-1:0] pri       = 24'h100000;
  logic [SAMPLE_W-1:0] sec       = 24'h100000;
  logic [SAMPLE_W-1:0] volt      = 24'h000000;
  logic [SAMPLE_W-1:0] cur;
  logic [7:0]          addr, wdata, rdata, d;
  logic                wr, rd, ind, fault, irq;
  int                  failures     = 0;
  int                  total_checks = 0;
  localparam logic [7:0] MAP [6] = '{ADDR_MODE_ONE, ADDR_ACC_MODE,
    ADDR_GAIN_LO, ADDR_GAIN_HI, ADDR_CAL_MODE, ADDR_IRQ_EN_LOW};
  localparam logic [7:0] VAL [6] = '{8'h20, 8'h40, 8'hA5, 8'h0F, 8'h30,
    8'h20};
  always #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    #1;
    stb = !stb && !rst_i;
  end
  cifs_cpu_model u_cpu (.clk_sys_i(clk_sys_i), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata));
  // short averaging counts keep the run brief
  cifs_core #(.AVG_CYC(20), .SWAP_CYC(60)) u_dut (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .sample_stb_i(stb),
    .primary_current_input_i(pri), .secondary_current_input_i(sec),
    .voltage_i(volt), .current_o(cur), .active_input_indicator_o(ind),
    .fault_o(fault), .irq_o(irq));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    u_cpu.rd(a, d);
    chk({16'h0000, d}, {16'h0000, exp});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // filters need a few thousand strobes, so the wait bound is generous
  task automatic wait_out(input logic on_ind, input logic val);
    int n;
    n = 0;
    while ((on_ind ? ind : fault) !== val && n < 20000) begin
      idle(1);
      n++;
    end
    chk(on_ind ? ind : fault, val);
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test();
  end
  initial begin
    idle(8);
    rst_i = 1'b0;
    foreach (MAP[i]) rchk(MAP[i], 8'h00);
    rchk(ADDR_IRQ_ST_LOW, 8'h00);
    rchk(8'h55, 8'h00);
    chk(ind, 1'b0);
    $display("reset test done");
    foreach (MAP[i]) begin
      u_cpu.wr(MAP[i], VAL[i]);
      rchk(MAP[i], VAL[i]);
    end
    for (int i = 0; i < 5; i++) u_cpu.wr(MAP[i], 8'h00);
    for (int c = 0; c < 4; c++) begin
      u_cpu.wr(ADDR_CAL_MODE, 8'(c << 4));
      idle(3);
      chk(ind, c >= 2);
      rchk(ADDR_ACC_MODE, {c >= 2, 7'h00});
    end
    $display("register test done");
    u_cpu.wr(ADDR_CAL_MODE, 8'h20);
    u_cpu.wr(ADDR_GAIN_HI, 8'h01);
    idle(4);
    chk(cur, 24'h110000);
    u_cpu.wr(ADDR_GAIN_HI, 8'h0F);
    idle(4);
    chk(cur, 24'h0F0000);
    u_cpu.wr(ADDR_GAIN_HI, 8'h00);
    u_cpu.wr(ADDR_CAL_MODE, 8'h10);
    idle(3);
    chk(ind, 1'b0);
    u_cpu.wr(ADDR_CAL_MODE, 8'h00);
    $display("trim test done");
    sec = 24'h0C0000;
    idle(6000);
    chk(fault, 1'b0);
    volt = 24'h100000;
    wait_out(1'b0, 1'b1);
    chk(ind, 1'b0);
    chk(cur, pri);
    rchk(ADDR_IRQ_ST_LOW, 8'h20);
    chk(irq, 1'b1);
    u_cpu.wr(ADDR_IRQ_EN_LOW, 8'h00);
    idle(3);
    chk(irq, 1'b0);
    u_cpu.wr(ADDR_IRQ_ST_LOW, 8'h00);
    rchk(ADDR_IRQ_ST_LOW, 8'h00);
    u_cpu.wr(ADDR_IRQ_EN_LOW, 8'h20);
    sec = pri;
    wait_out(1'b0, 1'b0);
    rchk(ADDR_IRQ_ST_LOW, 8'h20);
    sec = 24'h140000;
    wait_out(1'b1, 1'b1);
    chk(fault, 1'b1);
    chk(cur, sec);
    rchk(ADDR_ACC_MODE, 8'h80);
    pri = 24'h140000;
    wait_out(1'b0, 1'b0);
    chk(ind, 1'b1);
    pri = 24'h180000;
    wait_out(1'b1, 1'b0);
    $display("fault test done");
    u_cpu.wr(ADDR_IRQ_ST_LOW, 8'h00);
    u_cpu.wr(ADDR_ACC_MODE, 8'h40);
    pri = 24'h140000;
    wait_out(1'b0, 1'b0);
    rchk(ADDR_IRQ_ST_LOW, 8'h00);
    idle(1000);
    rchk(ADDR_IRQ_ST_LOW, 8'h20);
    u_cpu.wr(ADDR_MODE_ONE, 8'h20);
    idle(1);
    chk(cur, 24'h000000);
    u_cpu.wr(ADDR_MODE_ONE, 8'h00);
    idle(2);
    chk(cur, pri);
    $display("mode test done");
    stop_test();
  end
endmodule
